// ---- src/usb_irq_pkg.sv ----
// Package with register map, field positions and timing counts for USB interrupt logic
package usb_irq_pkg;
  // Register byte addresses (word aligned)
  localparam logic [3:0] addr_status_flag     = 4'h0;
  localparam logic [3:0] addr_status_enable   = 4'h4;
  localparam logic [3:0] addr_error_flag      = 4'h8;
  localparam logic [3:0] addr_error_enable    = 4'hc;
  localparam logic [3:0] addr_irq_control     = 4'h0;
  // Implemented bit masks
  localparam logic [7:0] status_mask          = 8'h7f;
  localparam logic [7:0] error_mask           = 8'h9f;
  // Status flag positions
  localparam int         sf_reset             = 0;
  localparam int         sf_error             = 1;
  localparam int         sf_activity          = 2;
  localparam int         sf_transaction       = 3;
  localparam int         sf_idle              = 4;
  localparam int         sf_stall             = 5;
  localparam int         sf_frame             = 6;
  // Error flag positions
  localparam int         ef_pid               = 0;
  localparam int         ef_crc5              = 1;
  localparam int         ef_crc16             = 2;
  localparam int         ef_dfsize            = 3;
  localparam int         ef_turnaround        = 4;
  localparam int         ef_bitstuff          = 7;
  // Reset values
  localparam logic [7:0] reg_reset            = 8'h00;
  // Timing
  localparam int         clk_mhz              = 250;
  localparam int         bit_rate_mhz         = 12;
  localparam int         turnaround_bits      = 16;
  localparam int         bit_cycles           = (clk_mhz + bit_rate_mhz - 1) / bit_rate_mhz;
  localparam int         turnaround_cycles    = turnaround_bits * bit_cycles;
  localparam int         idle_time_us         = 3000;
  localparam int         idle_cycles          = idle_time_us * clk_mhz;
  localparam int         cnt_w                = 20;
endpackage

// ---- src/usb_bus_timer.sv ----
// Counter that flags when a line has stayed idle beyond a limit
`timescale 1ns/1ps
`default_nettype none
module usb_bus_timer
  import usb_irq_pkg::*;
#(
  parameter int unsigned limit = 16
) (
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic restart,
  input  wire logic armed,
  output logic      expired
);
  logic [cnt_w-1:0] count_r;
  logic             done_r;

  // Count idle cycles, one expiry pulse per idle stretch
  always_ff @(posedge clock) begin
    if (sys_rst || restart || !armed) begin
      count_r <= '0;
      done_r  <= 1'b0;
    end else if (!done_r) begin
      if (count_r == cnt_w'(limit)) begin
        done_r <= 1'b1;
      end else begin
        count_r <= count_r + cnt_w'(1);
      end
    end
  end

  assign expired = armed && !done_r && !restart && (count_r == cnt_w'(limit));
endmodule // usb_bus_timer
`default_nettype wire

// ---- src/usb_irq_ctrl.sv ----
// USB interrupt enables, error flags, idle detect and summary interrupt logic
//
// The placing of the registers and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module usb_irq_ctrl
  import usb_irq_pkg::*;
#(
  parameter int unsigned idle_limit = idle_cycles
) (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Serial engine events, same clock
  input  wire logic        bit_stuff_err,
  input  wire logic        data_crc_err,
  input  wire logic        token_crc_err,
  input  wire logic        packet_id_err,
  input  wire logic        data_field_done,
  input  wire logic [2:0]  data_field_bits,
  input  wire logic        end_of_packet,
  input  wire logic        response_expected,
  input  wire logic        bit_strobe,
  input  wire logic        bus_activity,
  input  wire logic        frame_start_evt,
  input  wire logic        stall_sent_evt,
  input  wire logic        transaction_evt,
  input  wire logic        bus_reset_evt,
  input  wire logic        suspended,
  input  wire logic        module_enable,
  // Outputs
  output logic             token_reject,
  output logic             pullup_enable,
  output logic             module_interrupt_flag
);
  logic [7:0] status_interrupt_enable_r;
  logic [7:0] status_flag_r;
  logic [7:0] error_flag_status_r;
  logic [7:0] error_interrupt_enable_r;
  logic [7:0] status_events;
  logic [7:0] error_events;
  logic       error_summary_flag;
  logic       wr_lane0;
  logic       ack_r;
  logic       waiting_r;
  logic [7:0] ta_count_r;
  logic       turnaround_evt;
  logic       idle_evt;
  logic       idle_armed_r;
  logic [7:0] rd_byte;

  // Byte lane 0 carries all register bits
  assign wr_lane0 = avs_write && avs_byteenable[0] && ack_r;

  // One wait state per access, then acknowledge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read || avs_write) && !ack_r;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  // Error event vector in flag layout
  always_comb begin
    error_events                = 8'h00;
    error_events[ef_bitstuff]   = bit_stuff_err;
    error_events[ef_turnaround] = turnaround_evt;
    error_events[ef_dfsize]     = data_field_done && (data_field_bits != 3'h0);
    error_events[ef_crc16]      = data_crc_err;
    error_events[ef_crc5]       = token_crc_err;
    error_events[ef_pid]        = packet_id_err;
  end

  assign token_reject = token_crc_err;

  // Turnaround watchdog counted in bit times after end of packet
  always_ff @(posedge clock) begin
    if (sys_rst || bus_activity) begin
      waiting_r  <= 1'b0;
      ta_count_r <= 8'h00;
    end else if (end_of_packet) begin
      waiting_r  <= response_expected;
      ta_count_r <= 8'h00;
    end else if (waiting_r && bit_strobe) begin
      if (ta_count_r == 8'(turnaround_bits)) begin
        waiting_r <= 1'b0;
      end else begin
        ta_count_r <= ta_count_r + 8'h01;
      end
    end
  end
  // Seventeenth idle bit time means more than sixteen elapsed
  assign turnaround_evt = waiting_r && bit_strobe && !bus_activity && !end_of_packet
                          && (ta_count_r == 8'(turnaround_bits));

  // Error flags: hardware set beats software clear
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      error_flag_status_r <= reg_reset;
    end else begin
      if (wr_lane0 && avs_address == addr_error_flag) begin
        error_flag_status_r <= ((error_flag_status_r & avs_writedata[7:0]) | error_events)
                               & error_mask;
      end else begin
        error_flag_status_r <= (error_flag_status_r | error_events) & error_mask;
      end
    end
  end

  // Error enables
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      error_interrupt_enable_r <= reg_reset;
    end else if (wr_lane0 && avs_address == addr_error_enable) begin
      error_interrupt_enable_r <= avs_writedata[7:0] & error_mask;
    end
  end

  // Summary of enabled errors, combinational and read-only
  assign error_summary_flag = |(error_flag_status_r & error_interrupt_enable_r);

  // Idle detector armed by module enable, fires once per idle stretch
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      idle_armed_r <= 1'b0;
    end else begin
      idle_armed_r <= module_enable;
    end
  end

  usb_bus_timer #(
    .limit(idle_limit)
  ) u_idle_timer (
    .clock  (clock),
    .sys_rst(sys_rst),
    .restart(bus_activity),
    .armed  (idle_armed_r),
    .expired(idle_evt)
  );

  // Status events in status layout
  always_comb begin
    status_events                 = 8'h00;
    status_events[sf_reset]       = bus_reset_evt;
    status_events[sf_activity]    = bus_activity && suspended;
    status_events[sf_transaction] = transaction_evt;
    status_events[sf_idle]        = idle_evt;
    status_events[sf_stall]       = stall_sent_evt;
    status_events[sf_frame]       = frame_start_evt;
  end

  // Status flags; error bit mirrors summary and ignores writes
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_flag_r <= reg_reset;
    end else begin
      if (wr_lane0 && avs_address == addr_status_flag) begin
        status_flag_r <= ((status_flag_r & avs_writedata[7:0]) | status_events) & status_mask;
      end else begin
        status_flag_r <= (status_flag_r | status_events) & status_mask;
      end
    end
  end

  // Status enables
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      status_interrupt_enable_r <= reg_reset;
    end else if (wr_lane0 && avs_address == addr_status_enable) begin
      status_interrupt_enable_r <= avs_writedata[7:0] & status_mask;
    end
  end

  // Module interrupt from enabled status flags
  always_comb begin
    logic [7:0] flags;
    flags               = status_flag_r;
    flags[sf_error]     = error_summary_flag;
    module_interrupt_flag = |(flags & status_interrupt_enable_r);
  end

  // Pull-up held on whenever module enabled, suspended or not
  assign pullup_enable = module_enable;

  // Read mux
  always_comb begin
    rd_byte = 8'h00;
    case (avs_address)
      addr_status_flag: begin
        rd_byte           = status_flag_r;
        rd_byte[sf_error] = error_summary_flag;
      end
      addr_status_enable: rd_byte = status_interrupt_enable_r;
      addr_error_flag:    rd_byte = error_flag_status_r;
      addr_error_enable:  rd_byte = error_interrupt_enable_r;
      default:            rd_byte = 8'h00;
    endcase
  end

  // Registered read data
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= {24'h00_0000, rd_byte};
    end
  end
endmodule // usb_irq_ctrl
`default_nettype wire

// ---- tb/usb_irq_chk.sv ----
// Checker for bus timing, read masks and pin relations
`timescale 1ns/1ps
`default_nettype none
module usb_irq_chk
  import usb_irq_pkg::*;
(
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic        token_crc_err,
  input wire logic        token_reject,
  input wire logic        suspended,
  input wire logic        module_enable,
  input wire logic        pullup_enable,
  input wire logic        module_interrupt_flag,
  input wire logic [3:0]  avs_address,
  input wire logic [31:0] avs_readdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // Read answered in this cycle
  wire logic rd_ack = avs_read && !avs_waitrequest;
  wire logic req    = avs_read || avs_write;
  reject_tok_a: assert property (token_crc_err |-> token_reject)
    else $error("token not rejected");
  pullup_on_a: assert property (suspended |-> pullup_enable == module_enable)
    else $error("pullup dropped");
  wait_first_a: assert property (req && !$past(req) |-> avs_waitrequest)
    else $error("no wait state");
  wait_once_a: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait too long");
  status_bits_a: assert property (rd_ack && avs_address[3:2] != 2'b10
    && avs_address[3:2] != 2'b11 |-> avs_readdata[31:7] == 25'h0) else $error("status bit7");
  error_bits_a: assert property (rd_ack && avs_address[3] |->
    avs_readdata[31:8] == 24'h0 && avs_readdata[6:5] == 2'b00) else $error("error bits");
  unmapped_a: assert property (rd_ack && avs_address[1:0] != 2'b00 |-> avs_readdata == 32'h0)
    else $error("unmapped read");
  reset_quiet_a: assert property ($fell(sys_rst) |-> !module_interrupt_flag)
    else $error("irq after reset");
  read_c: cover property (rd_ack);
  irq_c: cover property (module_interrupt_flag);
  reject_c: cover property (token_reject);
endmodule // usb_irq_chk
bind usb_irq_ctrl usb_irq_chk chk (.*);
`default_nettype wire

// ---- tb/usb_host_model.sv ----
// Host side model: bit timing, packet end and bus traffic
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
  import usb_irq_pkg::*;
(
  input  wire logic clock,
  input  wire logic sys_rst,
  input  wire logic send_eop,
  input  wire logic traffic,
  output logic      bit_strobe,
  output logic      end_of_packet,
  output logic      response_expected,
  output logic      bus_activity
);
  logic [7:0] div_r;
  // One strobe per bit time
  always_ff @(posedge clock) begin
    if (sys_rst || div_r == 8'(bit_cycles - 1)) div_r <= 8'h00;
    else div_r <= div_r + 8'h01;
  end
  assign bit_strobe        = div_r == 8'h00 && !sys_rst;
  // Packet end that waits for an answer never sent
  assign end_of_packet     = send_eop;
  assign response_expected = send_eop;
  // Silence asks the device to suspend
  assign bus_activity      = traffic;
endmodule // usb_host_model
`default_nettype wire

// ---- tb/tb_usb_interrupt_enable_error_flags.sv ----
// Self-checking bench for USB interrupt enables and error flags
`timescale 1ns/1ps
`default_nettype none
module tb_usb_interrupt_enable_error_flags
  import usb_irq_pkg::*;
;
  logic        clock = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        send_eop = 1'b0, traffic = 1'b0, suspended = 1'b0, module_enable = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, rnd = 32'h97a5a42d, e;
  logic [11:0] ev = 12'h0;
  logic [2:0]  fbits = 3'h0;
  wire logic [31:0] avs_readdata;
  wire logic   avs_waitrequest, bit_strobe, end_of_packet, response_expected, bus_activity;
  wire logic   token_reject, pullup_enable, module_interrupt_flag;
  logic [31:0] exp_q[$];
  string       name_q[$];
  int          err_count = 0, n_checks = 0;
  int          ef[5] = '{ef_pid, ef_crc5, ef_crc16, ef_dfsize, ef_bitstuff};
  usb_irq_ctrl #(.idle_limit(50)) dut (.clock, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable(4'h1), .avs_readdata, .avs_waitrequest,
    .bit_stuff_err(ev[7]), .data_crc_err(ev[2]), .token_crc_err(ev[1]),
    .packet_id_err(ev[0]), .data_field_done(ev[3]), .data_field_bits(fbits),
    .end_of_packet, .response_expected, .bit_strobe, .bus_activity,
    .frame_start_evt(ev[11]), .stall_sent_evt(ev[10]), .transaction_evt(ev[9]),
    .bus_reset_evt(ev[8]), .suspended, .module_enable, .token_reject, .pullup_enable,
    .module_interrupt_flag);
  usb_host_model host (.clock, .sys_rst, .send_eop, .traffic, .bit_strobe,
    .end_of_packet, .response_expected, .bus_activity);
  initial forever #2 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] x);
    n_checks++;
    if (s !== x) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, x, s);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Avalon cycle held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clock); while (avs_waitrequest);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [3:0] a, input logic [31:0] x);
    name_q.push_back(n);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input logic [11:0] m);
    @(posedge clock);
    ev <= m;
    @(posedge clock);
    ev <= 12'h0;
  endtask
  // Read data taken at the rising edge that sees waitrequest low
  always @(posedge clock) begin
    if (avs_read && !avs_waitrequest) check(name_q.pop_front(), avs_readdata, exp_q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clock);
    err_count++;
    test_done();
  end
  initial begin
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    for (int i = 0; i < 16; i += 4) rd("reset", 4'(i), 32'h0);
    rnd = lfsr(rnd);
    bus(1'b1, addr_status_enable, rnd);
    rd("stat_en", addr_status_enable, rnd & 32'(status_mask));
    bus(1'b1, addr_error_enable, ~rnd);
    rd("err_en", addr_error_enable, ~rnd & 32'(error_mask));
    bus(1'b1, 4'h6, 32'hff);
    rd("unmapped", 4'h6, 32'h0);
    $display("register test done");
    bus(1'b1, addr_error_enable, 32'h0);
    pulse(12'h008);
    rd("size_whole", addr_error_flag, 32'h0);
    fbits <= rnd[2:0] | 3'h1;
    e = 32'h0;
    foreach (ef[i]) begin
      pulse(12'(1 << ef[i]));
      e[ef[i]] = 1'b1;
      rd("err_flag", addr_error_flag, e);
    end
    rd("sum_off", addr_status_flag, 32'h0);
    bus(1'b1, addr_error_enable, 32'h80);
    rd("sum_on", addr_status_flag, 32'h2);
    @(negedge clock);
    check("irq", 32'(module_interrupt_flag), 32'(rnd[1]));
    bus(1'b1, addr_status_enable, 32'h0);
    @(negedge clock);
    check("irq_off", 32'(module_interrupt_flag), 32'h0);
    bus(1'b1, addr_error_flag, 32'h7f);
    rd("clr_one", addr_error_flag, 32'h0f);
    bus(1'b1, addr_status_flag, 32'h02);
    rd("sum_ro", addr_status_flag, 32'h0);
    bus(1'b1, addr_error_flag, 32'h0);
    rd("clr_all", addr_error_flag, 32'h0);
    $display("error test done");
    pulse(12'hf00);
    rd("status", addr_status_flag, 32'h69);
    bus(1'b1, addr_status_enable, 32'h01);
    @(negedge clock);
    check("irq_rst", 32'(module_interrupt_flag), 32'h1);
    bus(1'b1, addr_status_flag, 32'h0);
    @(posedge bit_strobe);
    @(posedge clock);
    send_eop <= 1'b1;
    @(posedge clock);
    send_eop <= 1'b0;
    repeat (16) @(posedge bit_strobe);
    rd("bto_16", addr_error_flag, 32'h0);
    repeat (2) @(posedge bit_strobe);
    rd("bto_17", addr_error_flag, 32'h10);
    traffic <= 1'b1;
    module_enable <= 1'b1;
    bus(1'b1, addr_status_flag, 32'h0);
    traffic <= 1'b0;
    repeat (30) @(posedge clock);
    rd("busy", addr_status_flag, 32'h0);
    suspended <= 1'b1;
    repeat (40) @(posedge clock);
    rd("idle", addr_status_flag, 32'h10);
    @(negedge clock);
    check("pullup", 32'(pullup_enable), 32'h1);
    $display("bus test done");
    test_done();
  end
endmodule // tb_usb_interrupt_enable_error_flags
`default_nettype wire
